// >>> core/crd_regs.vh
// Constants for the processor register datapath: field layout, reset values and operation codes.
`ifndef CRD_REGS_VH
`define CRD_REGS_VH

`define CRD_PC_RESET 14'h0040
`define CRD_OP_HI 23
`define CRD_OP_LO 18
`define CRD_X_HI 17
`define CRD_X_LO 15
`define CRD_IND_BIT 14
`define CRD_O_HI 13
`define CRD_O_LO 0
`define CRD_REPL_HI 16
`define CRD_SHC_HI 5
`define CRD_IRQ_HI 5

`define CRD_OP_HLT 6'h00
`define CRD_OP_LDA 6'h01
`define CRD_OP_STA 6'h02
`define CRD_OP_ADD 6'h03
`define CRD_OP_SUB 6'h04
`define CRD_OP_AND 6'h05
`define CRD_OP_ORA 6'h06
`define CRD_OP_BRU 6'h07
`define CRD_OP_LDE 6'h08
`define CRD_OP_STE 6'h09
`define CRD_OP_XAX 6'h0A
`define CRD_OP_XXA 6'h0B
`define CRD_OP_ATX 6'h0C
`define CRD_OP_SLD 6'h10
`define CRD_OP_SRD 6'h11
`define CRD_OP_DSN 6'h12
`define CRD_OP_IOW 6'h18
`define CRD_OP_IOR 6'h19
`define CRD_OP_IRT 6'h1A

`endif

// >>> core/crd_index_file.v
// Eight-entry index register file with one write port and two read ports.
`timescale 1ns/100ps
module crd_index_file #(
    parameter WIDTH = 14
) (
    input wire clk,
    input wire srst,
    input wire we,
    input wire [2:0] waddr,
    input wire [WIDTH-1:0] wdata,
    input wire [2:0] raddr_a,
    output wire [WIDTH-1:0] rdata_a,
    input wire [2:0] raddr_b,
    output wire [WIDTH-1:0] rdata_b
);
    reg [WIDTH-1:0] regs_q [0:7];
    integer i;

    always @(posedge clk)
    begin
        if (srst)
        begin
            for (i = 0; i < 8; i = i + 1)
                regs_q[i] <= {WIDTH{1'b0}};
        end
        else if (we)
            regs_q[waddr] <= wdata;
    end

    assign rdata_a = regs_q[raddr_a];
    assign rdata_b = regs_q[raddr_b];
endmodule

// >>> core/crd_shift_counter.v
// Loadable down counter that paces shift instructions.
`timescale 1ns/100ps
module crd_shift_counter #(
    parameter WIDTH = 6
) (
    input wire clk,
    input wire srst,
    input wire load,
    input wire [WIDTH-1:0] load_val,
    input wire dec,
    output wire [WIDTH-1:0] count,
    output wire zero
);
    reg [WIDTH-1:0] cnt_q;

    always @(posedge clk)
    begin
        if (srst)
            cnt_q <= {WIDTH{1'b0}};
        else if (load)
            cnt_q <= load_val;
        else if (dec && cnt_q != {WIDTH{1'b0}})
            cnt_q <= cnt_q - {{(WIDTH-1){1'b0}}, 1'b1};
    end

    assign count = cnt_q;
    assign zero = (cnt_q == {WIDTH{1'b0}});
endmodule

// >>> core/crd_datapath.v
// Top of the processor register datapath with its fetch, execute and interrupt sequencer.
`timescale 1ns/100ps
`include "crd_regs.vh"

// What this block does
// - Program counter holds next address, steps by one on each fetch.
// - Panel reset loads the program counter with octal 100.
// - Panel switch register can load the program counter manually.
// - Taken branch puts operand address in program counter; fetching continues from there.
// - Eight index registers; only one to seven modify operand addresses.
// - Add-one-to-index compares odd register with next lower even register.
// - Double shift normalize leaves remaining count in index register zero.
// - Fetched words go to the 24-bit command register and are decoded.
// - Six opcode bits decode first and set meaning of other 18.
// - Indexed references add selected index register to operand address.
// - Indirect bit set: memory word replaces 17 address, indirect, index bits.
// - Shift loads 6-bit counter, decrements per shift, stops at zero.
// - Normalize also stops when top two bits of double word differ.
// - Non-instruction data to and from memory passes the buffer register.
// - Two-operand ops: buffer and accumulator feed arithmetic unit, result to accumulator.
// - Low 14 bits move either way between accumulator and any index register.
// - Accumulator and extension chain into one 48-bit register, shiftable both ways.
// - Double-precision value leaves the chain as two 24-bit halves.
// - Peripheral accumulator interface is 24 bits for data and commands.
// - Peripheral requests interrupt, then supplies address captured in interrupt register.
// - Interrupt address passes via command register to select first routine word.
// - Interrupt routine end resumes main program at next unexecuted instruction.
module crd_datapath (
    input wire CORE_CLK,
    input wire SRST,
    input wire PANEL_RESET,
    input wire PANEL_LOAD_PC,
    input wire PANEL_RUN,
    input wire [23:0] SWITCH_REG,
    output wire MEM_REQ,
    output wire MEM_WE,
    output wire [13:0] MEM_ADDR,
    output wire [23:0] MEM_WDATA,
    input wire MEM_ACK,
    input wire [23:0] MEM_RDATA,
    input wire PER_IRQ,
    input wire PER_ADDR_VALID,
    input wire [23:0] N_IN,
    output wire [23:0] N_OUT,
    output wire N_OUT_STB,
    output wire [13:0] PC_DISPLAY,
    output wire [23:0] ACC_DISPLAY,
    output wire [23:0] EXT_DISPLAY,
    output wire [5:0] INT_REG,
    output wire IN_INTERRUPT,
    output wire HALTED
);
    // ****************************************
    // States
    // ****************************************
    localparam S_IDLE = 4'h0;
    localparam S_FETCH = 4'h1;
    localparam S_FWAIT = 4'h2;
    localparam S_DEC = 4'h3;
    localparam S_INDW = 4'h4;
    localparam S_MEMW = 4'h5;
    localparam S_MWAIT = 4'h6;
    localparam S_EXEC = 4'h7;
    localparam S_SHIFT = 4'h8;
    localparam S_INTA = 4'h9;
    localparam S_INTV = 4'hA;
    localparam S_INTJ = 4'hB;

    reg [3:0] state_q;
    reg [13:0] pc_q;
    reg [13:0] ret_q;
    reg [23:0] c_q;
    reg [23:0] b_q;
    reg [23:0] a_q;
    reg [23:0] e_q;
    reg [5:0] r_q;
    reg irq_pend_q;
    reg in_irq_q;
    reg halted_q;
    reg mem_req_q;
    reg mem_we_q;
    reg [13:0] mem_addr_q;
    reg [23:0] mem_wdata_q;
    reg [23:0] n_out_q;
    reg n_stb_q;

    // ****************************************
    // Panel pin synchronisers
    // ****************************************
    // The panel lines are asynchronous pins; a level counts only once the
    // second and third stages agree, so a single glitch cannot start an action.
    reg [2:0] s1_q;
    reg [2:0] s2_q;
    reg [2:0] s3_q;
    reg [2:0] pin_f_q;
    reg [2:0] pin_prev_q;
    wire [2:0] pin_rise = pin_f_q & ~pin_prev_q;
    wire pnl_reset_ev = pin_rise[0];
    wire pnl_load_ev = pin_rise[1];
    wire run_f = pin_f_q[2];

    always @(posedge CORE_CLK)
    begin
        if (SRST)
        begin
            s1_q <= 3'h0;
            s2_q <= 3'h0;
            s3_q <= 3'h0;
            pin_f_q <= 3'h0;
            pin_prev_q <= 3'h0;
        end
        else
        begin
            s1_q <= {PANEL_RUN, PANEL_LOAD_PC, PANEL_RESET};
            s2_q <= s1_q;
            s3_q <= s2_q;
            pin_f_q <= (s2_q & s3_q) | (pin_f_q & (s2_q | s3_q));
            pin_prev_q <= pin_f_q;
        end
    end

    // ****************************************
    // Decode and address arithmetic
    // ****************************************
    wire [5:0] op = c_q[`CRD_OP_HI:`CRD_OP_LO];
    wire [2:0] xsel = c_q[`CRD_X_HI:`CRD_X_LO];
    wire [13:0] oaddr = c_q[`CRD_O_HI:`CRD_O_LO];
    wire is_atx = (op == `CRD_OP_ATX);
    wire [2:0] xra = is_atx ? {xsel[2:1], 1'b1} : xsel;
    wire [2:0] xrb = {xsel[2:1], 1'b0};
    wire [13:0] xa;
    wire [13:0] xb;
    // Index zero reads as no modification because there is no enable bit.
    wire [13:0] ea = oaddr + ((xsel != 3'h0) ? xa : 14'h0000);
    wire [13:0] xa_inc = xa + 14'h0001;
    wire mem_ref = (op == `CRD_OP_LDA) || (op == `CRD_OP_STA) || (op == `CRD_OP_ADD) ||
                   (op == `CRD_OP_SUB) || (op == `CRD_OP_AND) || (op == `CRD_OP_ORA) ||
                   (op == `CRD_OP_LDE) || (op == `CRD_OP_STE) || (op == `CRD_OP_BRU);
    wire is_dsn = (op == `CRD_OP_DSN);

    // Arithmetic unit: buffer supplies the fetched operand, accumulator the held one.
    reg [23:0] au_res;
    always @*
    begin
        case (op)
            `CRD_OP_ADD: au_res = a_q + b_q;
            `CRD_OP_SUB: au_res = a_q - b_q;
            `CRD_OP_AND: au_res = a_q & b_q;
            `CRD_OP_ORA: au_res = a_q | b_q;
            default: au_res = b_q;
        endcase
    end

    // ****************************************
    // Index file and shift counter control
    // ****************************************
    wire [5:0] sc_count;
    wire sc_zero;
    wire shift_stop = sc_zero || (is_dsn && (a_q[23] != a_q[22]));
    reg idx_we;
    reg [2:0] idx_waddr;
    reg [13:0] idx_wdata;
    reg sc_load;
    reg sc_dec;

    always @*
    begin
        idx_we = 1'b0;
        idx_waddr = xsel;
        idx_wdata = a_q[13:0];
        sc_load = 1'b0;
        sc_dec = 1'b0;
        if (state_q == S_DEC && !pnl_reset_ev)
        begin
            if (op == `CRD_OP_XAX)
                idx_we = 1'b1;
            if (is_atx)
            begin
                idx_we = 1'b1;
                idx_waddr = xra;
                idx_wdata = xa_inc;
            end
            if (op == `CRD_OP_SLD || op == `CRD_OP_SRD || is_dsn)
                sc_load = 1'b1;
        end
        if (state_q == S_SHIFT && !pnl_reset_ev)
        begin
            if (shift_stop && is_dsn)
            begin
                idx_we = 1'b1;
                idx_waddr = 3'h0;
                idx_wdata = {8'h00, sc_count};
            end
            sc_dec = !shift_stop;
        end
    end

    crd_index_file #(.WIDTH(14)) u_index (
        .clk(CORE_CLK),
        .srst(SRST),
        .we(idx_we),
        .waddr(idx_waddr),
        .wdata(idx_wdata),
        .raddr_a(xra),
        .rdata_a(xa),
        .raddr_b(xrb),
        .rdata_b(xb)
    );

    crd_shift_counter #(.WIDTH(6)) u_shift (
        .clk(CORE_CLK),
        .srst(SRST),
        .load(sc_load),
        .load_val(c_q[`CRD_SHC_HI:0]),
        .dec(sc_dec),
        .count(sc_count),
        .zero(sc_zero)
    );

    // ****************************************
    // Sequencer and registers
    // ****************************************
    wire irq_take = (state_q == S_IDLE) && run_f && !halted_q && irq_pend_q && !in_irq_q;

    always @(posedge CORE_CLK)
    begin
        if (SRST)
        begin
            state_q <= S_IDLE;
            pc_q <= `CRD_PC_RESET;
            ret_q <= 14'h0000;
            c_q <= 24'h000000;
            b_q <= 24'h000000;
            a_q <= 24'h000000;
            e_q <= 24'h000000;
            r_q <= 6'h00;
            irq_pend_q <= 1'b0;
            in_irq_q <= 1'b0;
            halted_q <= 1'b0;
            mem_req_q <= 1'b0;
            mem_we_q <= 1'b0;
            mem_addr_q <= 14'h0000;
            mem_wdata_q <= 24'h000000;
            n_out_q <= 24'h000000;
            n_stb_q <= 1'b0;
        end
        else
        begin
            n_stb_q <= 1'b0;
            // A new request wins over the clear made by acceptance.
            irq_pend_q <= PER_IRQ | (irq_pend_q & ~irq_take);
            if (!run_f)
                halted_q <= 1'b0;
            if (pnl_reset_ev)
            begin
                // Abandons any transfer in flight; memory must tolerate a dropped request.
                pc_q <= `CRD_PC_RESET;
                irq_pend_q <= PER_IRQ;
                in_irq_q <= 1'b0;
                mem_req_q <= 1'b0;
                mem_we_q <= 1'b0;
                state_q <= S_IDLE;
            end
            else
            begin
                case (state_q)
                    S_IDLE:
                    begin
                        if (pnl_load_ev && !run_f)
                            pc_q <= SWITCH_REG[13:0];
                        else if (irq_take)
                            state_q <= S_INTA;
                        else if (run_f && !halted_q)
                            state_q <= S_FETCH;
                    end
                    S_FETCH:
                    begin
                        mem_req_q <= 1'b1;
                        mem_we_q <= 1'b0;
                        mem_addr_q <= pc_q;
                        state_q <= S_FWAIT;
                    end
                    S_FWAIT:
                    begin
                        if (MEM_ACK)
                        begin
                            mem_req_q <= 1'b0;
                            c_q <= MEM_RDATA;
                            pc_q <= pc_q + 14'h0001;
                            state_q <= S_DEC;
                        end
                    end
                    S_DEC:
                    begin
                        state_q <= S_IDLE;
                        if (mem_ref && c_q[`CRD_IND_BIT])
                        begin
                            mem_req_q <= 1'b1;
                            mem_we_q <= 1'b0;
                            mem_addr_q <= oaddr;
                            state_q <= S_INDW;
                        end
                        else
                        begin
                            case (op)
                                `CRD_OP_LDA, `CRD_OP_ADD, `CRD_OP_SUB, `CRD_OP_AND,
                                `CRD_OP_ORA, `CRD_OP_LDE:
                                begin
                                    mem_req_q <= 1'b1;
                                    mem_we_q <= 1'b0;
                                    mem_addr_q <= ea;
                                    state_q <= S_MWAIT;
                                end
                                `CRD_OP_STA:
                                begin
                                    b_q <= a_q;
                                    state_q <= S_MEMW;
                                end
                                `CRD_OP_STE:
                                begin
                                    b_q <= e_q;
                                    state_q <= S_MEMW;
                                end
                                `CRD_OP_BRU: pc_q <= ea;
                                `CRD_OP_XXA: a_q <= {10'h000, xa};
                                `CRD_OP_ATX:
                                begin
                                    // Loop continues by branching until the odd register meets its partner.
                                    if (xa_inc != xb)
                                        pc_q <= oaddr;
                                end
                                `CRD_OP_SLD, `CRD_OP_SRD, `CRD_OP_DSN: state_q <= S_SHIFT;
                                `CRD_OP_IOW:
                                begin
                                    n_out_q <= a_q;
                                    n_stb_q <= 1'b1;
                                end
                                `CRD_OP_IOR:
                                begin
                                    b_q <= N_IN;
                                    state_q <= S_EXEC;
                                end
                                `CRD_OP_IRT:
                                begin
                                    pc_q <= ret_q;
                                    in_irq_q <= 1'b0;
                                end
                                `CRD_OP_HLT: halted_q <= 1'b1;
                                default: state_q <= S_IDLE;
                            endcase
                        end
                    end
                    S_INDW:
                    begin
                        if (MEM_ACK)
                        begin
                            mem_req_q <= 1'b0;
                            c_q[`CRD_REPL_HI:0] <= MEM_RDATA[`CRD_REPL_HI:0];
                            state_q <= S_DEC;
                        end
                    end
                    S_MEMW:
                    begin
                        mem_req_q <= 1'b1;
                        mem_we_q <= 1'b1;
                        mem_addr_q <= ea;
                        mem_wdata_q <= b_q;
                        state_q <= S_MWAIT;
                    end
                    S_MWAIT:
                    begin
                        if (MEM_ACK)
                        begin
                            mem_req_q <= 1'b0;
                            mem_we_q <= 1'b0;
                            if (!mem_we_q)
                            begin
                                b_q <= MEM_RDATA;
                                state_q <= S_EXEC;
                            end
                            else
                                state_q <= S_IDLE;
                        end
                    end
                    S_EXEC:
                    begin
                        if (op == `CRD_OP_LDE)
                            e_q <= b_q;
                        else
                            a_q <= au_res;
                        state_q <= S_IDLE;
                    end
                    S_SHIFT:
                    begin
                        if (shift_stop)
                            state_q <= S_IDLE;
                        else if (op == `CRD_OP_SRD)
                            {a_q, e_q} <= {a_q[23], a_q, e_q[23:1]};
                        else
                            {a_q, e_q} <= {a_q[22:0], e_q, 1'b0};
                    end
                    S_INTA:
                    begin
                        if (PER_ADDR_VALID)
                        begin
                            r_q <= N_IN[`CRD_IRQ_HI:0];
                            state_q <= S_INTV;
                        end
                    end
                    S_INTV:
                    begin
                        c_q[`CRD_O_HI:`CRD_O_LO] <= {8'h00, r_q};
                        state_q <= S_INTJ;
                    end
                    S_INTJ:
                    begin
                        ret_q <= pc_q;
                        pc_q <= oaddr;
                        in_irq_q <= 1'b1;
                        state_q <= S_FETCH;
                    end
                    default: state_q <= S_IDLE;
                endcase
            end
        end
    end

    assign MEM_REQ = mem_req_q;
    assign MEM_WE = mem_we_q;
    assign MEM_ADDR = mem_addr_q;
    assign MEM_WDATA = mem_wdata_q;
    assign N_OUT = n_out_q;
    assign N_OUT_STB = n_stb_q;
    assign PC_DISPLAY = pc_q;
    assign ACC_DISPLAY = a_q;
    assign EXT_DISPLAY = e_q;
    assign INT_REG = r_q;
    assign IN_INTERRUPT = in_irq_q;
    assign HALTED = halted_q;
endmodule

// >>> testbench/crd_datapath_chk.sv
// Port checker for the processor register datapath.
`timescale 1ns/100ps
module crd_datapath_chk (
    input wire CORE_CLK,
    input wire SRST,
    input wire PANEL_RESET,
    input wire MEM_REQ,
    input wire MEM_WE,
    input wire [13:0] MEM_ADDR,
    input wire MEM_ACK,
    input wire [23:0] N_OUT,
    input wire N_OUT_STB,
    input wire [13:0] PC_DISPLAY,
    input wire [23:0] ACC_DISPLAY,
    input wire HALTED
);
    reg [13:0] ack_addr_q;
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (SRST);
    // Remembers the address of the last finished transfer for the fetch step check.
    always @(posedge CORE_CLK)
    begin
        if (MEM_REQ && MEM_ACK)
            ack_addr_q <= MEM_ADDR;
    end
    // ************************************************************
    // Assertions
    // ************************************************************
    AST_REQ_HOLD: assert property (
        MEM_REQ && !MEM_ACK |=> MEM_REQ && $stable(MEM_ADDR) && $stable(MEM_WE))
        else $error("memory request changed before acknowledge");
    AST_REQ_DROP: assert property (
        MEM_REQ && MEM_ACK |=> !MEM_REQ)
        else $error("memory request not dropped after acknowledge");
    AST_PC_STEP: assert property (
        MEM_REQ && MEM_ACK && !MEM_WE && MEM_ADDR == PC_DISPLAY
        |-> ##[1:2] PC_DISPLAY == ack_addr_q + 14'h0001)
        else $error("program counter did not step after fetch");
    AST_SRST_CLEAR: assert property (disable iff (1'b0)
        SRST |=> PC_DISPLAY == 14'h0040 && !MEM_REQ && !N_OUT_STB)
        else $error("reset state wrong");
    AST_PANEL_RESET: assert property (
        $rose(PANEL_RESET) |-> ##[2:8] PC_DISPLAY == 14'h0040 && !MEM_REQ)
        else $error("panel reset did not restore program counter");
    AST_STB_PULSE: assert property (
        N_OUT_STB |=> !N_OUT_STB)
        else $error("peripheral strobe longer than one cycle");
    AST_NOUT_ACC: assert property (
        N_OUT_STB |-> N_OUT == ACC_DISPLAY)
        else $error("peripheral output differs from accumulator");
    AST_HALT_QUIET: assert property (
        HALTED |-> !MEM_REQ)
        else $error("memory request while halted");
endmodule

// >>> testbench/crd_mem_model.sv
// Behavioural core memory that answers the datapath's requests.
`timescale 1ns/100ps
module crd_mem_model (
    input wire clk,
    input wire req,
    input wire we,
    input wire [13:0] addr,
    input wire [23:0] wdata,
    input wire [1:0] lat,
    output reg ack,
    output reg [23:0] rdata
);
    reg [23:0] mem [0:16383];
    reg [1:0] wait_q;
    initial
    begin
        ack = 1'b0;
        rdata = 24'h000000;
        wait_q = 2'h0;
    end
    always @(posedge clk)
    begin
        ack <= 1'b0;
        // Read data is only good with the acknowledge; otherwise it churns every cycle.
        rdata <= ~rdata;
        if (req && !ack)
        begin
            if (wait_q == lat)
            begin
                ack <= 1'b1;
                wait_q <= 2'h0;
                if (we)
                    mem[addr] <= wdata;
                else
                    rdata <= mem[addr];
            end
            else
                wait_q <= wait_q + 2'h1;
        end
    end
endmodule

// >>> testbench/crd_datapath_test.sv
// Self-checking bench for the processor register datapath.
`timescale 1ns/100ps
`include "crd_regs.vh"
module crd_datapath_test;
    reg clk = 1'b0;
    reg srst = 1'b1;
    reg panel_reset = 1'b0;
    reg panel_load = 1'b0;
    reg panel_run = 1'b0;
    reg [23:0] switches = 24'h000000;
    reg [1:0] mem_lat = 2'h0;
    reg per_irq = 1'b0;
    reg per_av = 1'b0;
    reg [23:0] n_in = 24'h000000;
    wire mem_req, mem_we, mem_ack, n_stb, halted, in_irq;
    wire [13:0] mem_addr, pc;
    wire [23:0] mem_wdata, mem_rdata, n_out, acc;
    wire [5:0] int_reg;
    integer err_count = 0;
    integer num_checks = 0;
    integer i;
    reg [23:0] v1, v2;
    reg [37:0] w;
    reg [37:0] wq[$];
    reg [23:0] nq[$];
    crd_datapath u_dut (.CORE_CLK(clk), .SRST(srst), .PANEL_RESET(panel_reset),
        .PANEL_LOAD_PC(panel_load), .PANEL_RUN(panel_run), .SWITCH_REG(switches),
        .MEM_REQ(mem_req), .MEM_WE(mem_we), .MEM_ADDR(mem_addr), .MEM_WDATA(mem_wdata),
        .MEM_ACK(mem_ack), .MEM_RDATA(mem_rdata), .PER_IRQ(per_irq), .PER_ADDR_VALID(per_av),
        .N_IN(n_in), .N_OUT(n_out), .N_OUT_STB(n_stb), .PC_DISPLAY(pc),
        .ACC_DISPLAY(acc), .EXT_DISPLAY(), .INT_REG(int_reg), .IN_INTERRUPT(in_irq),
        .HALTED(halted));
    crd_mem_model u_mem (.clk(clk), .req(mem_req), .we(mem_we), .addr(mem_addr),
        .wdata(mem_wdata), .lat(mem_lat), .ack(mem_ack), .rdata(mem_rdata));
    function [23:0] ins(input [5:0] op, input [2:0] x, input ind, input [13:0] o);
        ins = {op, x, ind, o};
    endfunction
    task check(input string name, input [23:0] exp, input [23:0] got);
    begin
        num_checks = num_checks + 1;
        if (got !== exp)
        begin
            err_count = err_count + 1;
            $display("ERROR %0s expected %h seen %h", name, exp, got);
        end
    end
    endtask
    task give_verdict;
    begin
        $display("Checks %0d, errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    end
    endtask
    initial
    begin
        forever #5 clk = ~clk;
    end
    initial
    begin
        repeat (20000) @(posedge clk);
        err_count = err_count + 1;
        give_verdict;
    end
    // Writes and peripheral strobes are matched in order against the notes of the driver.
    always @(posedge clk)
    begin
        if ((mem_req & mem_we & mem_ack) === 1'b1)
        begin
            w = (wq.size() > 0) ? wq.pop_front() : 38'h0;
            check("wr_addr", {10'h000, w[37:24]}, {10'h000, mem_addr});
            check("wr_data", w[23:0], mem_wdata);
        end
        if (n_stb === 1'b1)
            check("n_out", (nq.size() > 0) ? nq.pop_front() : 24'h0, n_out);
    end
    // ************************************************************
    // Scenarios
    // ************************************************************
    initial
    begin
        void'($urandom(66));
        v1 = $urandom;
        v2 = $urandom;
        mem_lat = $urandom % 4;
        switches = $urandom;
        u_mem.mem[14'h0100] = v1;
        u_mem.mem[14'h0101] = v2;
        u_mem.mem[14'h0103] = 24'h000005;
        // Indirect word sets operand 0x300 and index low bits 11.
        u_mem.mem[14'h0104] = 24'h018300;
        u_mem.mem[14'h0030] = ins(`CRD_OP_IOW, 3'h0, 1'b0, 14'h0000);
        u_mem.mem[14'h0031] = ins(`CRD_OP_IRT, 3'h0, 1'b0, 14'h0000);
        u_mem.mem[14'h0040] = ins(`CRD_OP_LDA, 3'h0, 1'b0, 14'h0100);
        u_mem.mem[14'h0041] = ins(`CRD_OP_ADD, 3'h0, 1'b0, 14'h0101);
        u_mem.mem[14'h0042] = ins(`CRD_OP_STA, 3'h0, 1'b0, 14'h0102);
        u_mem.mem[14'h0043] = ins(`CRD_OP_SUB, 3'h0, 1'b0, 14'h0101);
        u_mem.mem[14'h0044] = ins(`CRD_OP_IOW, 3'h0, 1'b0, 14'h0000);
        u_mem.mem[14'h0045] = ins(`CRD_OP_LDA, 3'h0, 1'b0, 14'h0103);
        u_mem.mem[14'h0046] = ins(`CRD_OP_XAX, 3'h3, 1'b0, 14'h0000);
        u_mem.mem[14'h0047] = ins(`CRD_OP_STA, 3'h3, 1'b0, 14'h0200);
        u_mem.mem[14'h0048] = ins(`CRD_OP_STA, 3'h0, 1'b1, 14'h0104);
        u_mem.mem[14'h0049] = ins(`CRD_OP_SLD, 3'h0, 1'b0, 14'h0004);
        u_mem.mem[14'h004A] = ins(`CRD_OP_STA, 3'h0, 1'b0, 14'h0106);
        u_mem.mem[14'h004B] = ins(`CRD_OP_BRU, 3'h0, 1'b0, 14'h0060);
        u_mem.mem[14'h004C] = ins(`CRD_OP_IOW, 3'h0, 1'b0, 14'h0000);
        u_mem.mem[14'h0060] = ins(`CRD_OP_IOW, 3'h0, 1'b0, 14'h0000);
        u_mem.mem[14'h0061] = ins(`CRD_OP_DSN, 3'h0, 1'b0, 14'h0014);
        u_mem.mem[14'h0062] = ins(`CRD_OP_STA, 3'h0, 1'b0, 14'h0107);
        u_mem.mem[14'h0063] = ins(`CRD_OP_ATX, 3'h1, 1'b0, 14'h0063);
        u_mem.mem[14'h0064] = ins(`CRD_OP_XXA, 3'h1, 1'b0, 14'h0000);
        u_mem.mem[14'h0065] = ins(`CRD_OP_IOW, 3'h0, 1'b0, 14'h0000);
        u_mem.mem[14'h0066] = ins(`CRD_OP_HLT, 3'h0, 1'b0, 14'h0000);
        wq.push_back({14'h0102, v1 + v2});
        nq.push_back(24'h000000);
        nq.push_back(v1);
        wq.push_back({14'h0205, 24'h000005});
        wq.push_back({14'h0305, 24'h000005});
        wq.push_back({14'h0106, 24'h000050});
        nq.push_back(24'h000050);
        wq.push_back({14'h0107, 24'h500000});
        nq.push_back(24'h000004);
        repeat (5) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        check("pc_rst", {10'h000, `CRD_PC_RESET}, {10'h000, pc});
        panel_load <= 1'b1;
        repeat (8) @(posedge clk);
        panel_load <= 1'b0;
        repeat (8) @(posedge clk);
        check("pc_load", {10'h000, switches[13:0]}, {10'h000, pc});
        panel_reset <= 1'b1;
        repeat (8) @(posedge clk);
        panel_reset <= 1'b0;
        repeat (8) @(posedge clk);
        check("pc_panel", {10'h000, `CRD_PC_RESET}, {10'h000, pc});
        panel_run <= 1'b1;
        per_irq <= 1'b1;
        @(posedge clk);
        per_irq <= 1'b0;
        repeat (12) @(posedge clk);
        n_in <= {v1[17:0], 6'h30};
        per_av <= 1'b1;
        @(posedge clk);
        per_av <= 1'b0;
        i = 0;
        while (halted !== 1'b1 && i < 3000)
        begin
            @(posedge clk);
            i = i + 1;
        end
        repeat (4) @(posedge clk);
        check("halted", 24'h000001, {23'h000000, halted});
        check("pc_halt", 24'h000067, {10'h000, pc});
        check("pending", 24'h000000, wq.size() + nq.size());
        check("int_reg", 24'h000030, {18'h00000, int_reg});
        check("in_irq", 24'h000000, {23'h000000, in_irq});
        check("acc", 24'h000004, acc);
        give_verdict;
    end
endmodule
bind crd_datapath crd_datapath_chk u_chk (.CORE_CLK(CORE_CLK), .SRST(SRST),
    .PANEL_RESET(PANEL_RESET), .MEM_REQ(MEM_REQ), .MEM_WE(MEM_WE), .MEM_ADDR(MEM_ADDR),
    .MEM_ACK(MEM_ACK), .N_OUT(N_OUT), .N_OUT_STB(N_OUT_STB), .PC_DISPLAY(PC_DISPLAY),
    .ACC_DISPLAY(ACC_DISPLAY), .HALTED(HALTED));
